// ### rtl/sys_bus_pkg.sv
// shared constants and the lane parity function for the synchronous processor system bus
package sys_bus_pkg;
   localparam int ADDR_W          = 32;
   localparam int DATA_W          = 32;
   localparam int LANES           = 4;
   localparam int AT_W            = 4;
   localparam int CS_NUM          = 8;
   localparam int BURST_BEATS     = 4;
   localparam int CLK_HZ          = 125_000_000;
   localparam int TIMEOUT_NS      = 2000;
   localparam int TIMEOUT_CYC     = (TIMEOUT_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int SLAVE_WAIT      = 2;
   localparam logic [1:0] SIZE_32 = 2'h0;
   localparam logic [1:0] SIZE_8  = 2'h1;
   localparam logic [1:0] SIZE_16 = 2'h2;
   localparam logic [3:0] AT_NORMAL = 4'h0;
   localparam logic [3:0] AT_BURST  = 4'h1;
   localparam logic [3:0] AT_DMA    = 4'h2;

   // even parity per byte lane, lane 0 is the most significant byte
   function automatic logic [3:0] lane_parity(input logic [31:0] d);
      logic [3:0] p;
      p = 4'h0;
      for (int i = 0; i < 4; i++) begin
         p[i] = ^d[31 - 8 * i -: 8];
      end
      return p;
   endfunction
endpackage

// ### rtl/sys_bus_if.sv
// bus wires between master and slave, with one modport for each end
interface sys_bus_if;
   logic [31:0] addr;
   logic [1:0]  transfer_size;
   logic        read_not_write;
   logic [3:0]  address_type;
   logic        transfer_start_n;
   logic        burst_in_progress_n;
   logic [31:0] wdata;
   logic [3:0]  wpar;
   logic [31:0] rdata;
   logic [3:0]  rpar;
   logic        transfer_ack_n;
   logic        transfer_error_ack_n;
   logic        burst_inhibit_n;
   logic        slave_error_ack_n;
   logic [7:0]  chip_select_n;

   modport master (
      output addr, transfer_size, read_not_write, address_type,
      output transfer_start_n, burst_in_progress_n, wdata, wpar,
      output transfer_error_ack_n, chip_select_n,
      input  rdata, rpar, transfer_ack_n, burst_inhibit_n,
      input  slave_error_ack_n
   );
   modport slave (
      input  addr, transfer_size, read_not_write, address_type,
      input  transfer_start_n, burst_in_progress_n, wdata, wpar,
      input  transfer_error_ack_n, chip_select_n,
      output rdata, rpar, transfer_ack_n, burst_inhibit_n,
      output slave_error_ack_n
   );
endinterface

// ### rtl/bus_master.sv
// bus master: starts transfers, bursts, time-out and parity checks
// Functional notes
// RULE1: start pulses low one cycle with address
// RULE2: size code sent with address
// RULE3: read_not_write high on reads, low writes
// RULE4: four-bit address type sent with address
// RULE5: slave acknowledges with one-cycle low pulse
// RULE6: no new start until acknowledge negated
// RULE7: transfer lasts at least two clocks
// RULE8: error acknowledge aborts current cycle
// RULE9: slave may flag error on bad parity
// RULE10: master times out unanswered cycles
// RULE11: lane usage depends on transfer size
// RULE12: one parity bit per byte lane
// RULE13: bit 0 is most significant
// RULE14: all signals on master clock rising edge
// RULE15: optional half-rate bus clock enable
// RULE16: bursts are aligned four 32-bit words
// RULE17: slave advances word bits during burst; this slave inhibits every burst and reloads word from addr[3:2] at each start
// RULE18: burst inhibit falls back to single cycles
// RULE19: slave refuses bursts when burst flagged
// RULE20: eight chip selects, each timer-typed
// RULE21: memory mapped only, no I/O space
// RULE22: bursts only for line fills and DMA
// RULE23: slave never acks and errors together
module bus_master
   import sys_bus_pkg::*;
#(
   parameter int TIMEOUT = TIMEOUT_CYC
) (
   input  wire logic                        clock_in,
   input  wire logic                        rst_in,
   input  wire logic                        half_rate_in,
   input  wire logic [7:0]                  cs_use_pattern_in,
   input  wire logic                        req_valid_in,
   output      logic                        req_ready_out,
   input  wire logic [31:0]                 req_addr_in,
   input  wire logic [1:0]                  req_size_in,
   input  wire logic                        req_read_in,
   input  wire logic                        req_burst_in,
   input  wire logic [3:0]                  req_type_in,
   input  wire logic [127:0]                req_wdata_in,
   output      logic                        rsp_valid_out,
   output      logic [127:0]                rsp_rdata_out,
   output      logic                        rsp_error_out,
   output      logic                        rsp_timeout_out,
   output      logic                        rsp_parity_err_out,
   output      logic [7:0]                  cs_pattern_out,
   sys_bus_if.master                        bus
);
   import sys_bus_pkg::*;

   typedef enum logic [1:0] {IDLE, ADDR, WAIT, RECOVER} st_e;

   typedef struct packed {
      st_e          st;
      logic         div;
      logic [31:0]  addr;
      logic [1:0]   size;
      logic         rd;
      logic [3:0]   at;
      logic         burst;
      logic         bursting;
      logic [1:0]   beat;
      logic [127:0] wbuf;
      logic [127:0] rbuf;
      logic         start_n;
      logic [31:0]  wdata;
      logic [3:0]   wpar;
      logic         tea_n;
      logic [15:0]  tmo;
      logic         done;
      logic         err;
      logic         tmo_hit;
      logic         perr;
      logic [7:0]   cs_n;
   } state_s;

   state_s s_r, s_nxt;
   logic   tick;
   logic   ack;
   logic   err_in;
   logic   perr_now;
   logic [31:0] beat_addr;

   ////////////////////////////////////////////////////////////////////////
   // bus enable: every cycle, or every other one in half-rate mode
   assign tick = !half_rate_in || s_r.div;                    // [RULE15]
   assign ack = tick && !bus.transfer_ack_n;                  // [RULE14]
   assign err_in = tick && (!bus.slave_error_ack_n || !s_r.tea_n);
   // data byte order big-endian: lane 0 sits in bits 31:24
   assign perr_now = s_r.rd &&
      (lane_parity(bus.rdata) != bus.rpar);                   // [RULE12]
   // single-beat fallback walks the word bits itself
   assign beat_addr = {s_r.addr[31:4], s_r.beat, 2'h0};       // [RULE18]

   // address and data ports come from flip-flops
   assign bus.addr                = s_r.addr;
   assign bus.transfer_size       = s_r.size;                 // [RULE2]
   assign bus.read_not_write      = s_r.rd;                   // [RULE3]
   assign bus.address_type        = s_r.at;                   // [RULE4]
   assign bus.transfer_start_n    = s_r.start_n;              // [RULE1]
   assign bus.burst_in_progress_n = !s_r.bursting;
   assign bus.wdata               = s_r.wdata;
   assign bus.wpar                = s_r.wpar;
   assign bus.transfer_error_ack_n = s_r.tea_n;               // [RULE10]
   assign bus.chip_select_n       = s_r.cs_n;
   assign req_ready_out           = (s_r.st == IDLE);
   assign rsp_valid_out           = s_r.done;
   assign rsp_rdata_out           = s_r.rbuf;
   assign rsp_error_out           = s_r.err;
   assign rsp_timeout_out         = s_r.tmo_hit;
   assign rsp_parity_err_out      = s_r.perr;
   // chip select timer kind per select; this end only forwards it
   assign cs_pattern_out          = cs_use_pattern_in;        // [RULE20]

   ////////////////////////////////////////////////////////////////////////
   // next-state logic for the transfer sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.div = !s_r.div;
      s_nxt.done = 1'b0;
      if (tick) begin
         s_nxt.start_n = 1'b1;                                // [RULE1]
         s_nxt.tea_n = 1'b1;
      end
      case (s_r.st)
         IDLE: begin
            if (req_valid_in && tick) begin
               s_nxt.st = ADDR;
               s_nxt.start_n = 1'b0;                          // [RULE1]
               // burst only for fills and dma types
               s_nxt.burst = req_burst_in && req_read_in &&
                  (req_type_in == AT_BURST ||
                   req_type_in == AT_DMA);                    // [RULE22]
               s_nxt.bursting = s_nxt.burst;
               s_nxt.size = s_nxt.burst ? SIZE_32 : req_size_in;
               s_nxt.addr = s_nxt.burst ?
                  {req_addr_in[31:4], 4'h0} : req_addr_in;    // [RULE16]
               s_nxt.rd = req_read_in;
               s_nxt.at = req_type_in;
               s_nxt.beat = 2'h0;
               s_nxt.wbuf = req_wdata_in;
               s_nxt.wdata = req_wdata_in[127:96];            // [RULE13]
               s_nxt.wpar = lane_parity(req_wdata_in[127:96]); // [RULE12]
               s_nxt.rbuf = '0;
               s_nxt.err = 1'b0;
               s_nxt.tmo_hit = 1'b0;
               s_nxt.perr = 1'b0;
               s_nxt.tmo = '0;
               // plain memory-mapped decode, top three bits pick select
               s_nxt.cs_n = ~(8'h01 << req_addr_in[31:29]);   // [RULE21]
            end
         end
         ADDR: begin
            // acknowledge is not looked at in the start cycle
            if (tick) begin
               s_nxt.st = WAIT;                               // [RULE7]
            end
         end
         WAIT: begin
            if (tick) begin
               s_nxt.tmo = s_r.tmo + 16'h1;
            end
            if (err_in) begin
               s_nxt.st = RECOVER;                            // [RULE8]
               s_nxt.err = 1'b1;
               s_nxt.bursting = 1'b0;
               s_nxt.cs_n = 8'hff;
            end else if (ack) begin
               s_nxt.rbuf[127 - 32 * s_r.beat -: 32] = bus.rdata;
               s_nxt.perr = s_r.perr || perr_now;             // [RULE12]
               s_nxt.tmo = '0;
               s_nxt.beat = s_r.beat + 2'h1;
               if (s_r.beat == 2'(BURST_BEATS - 1) ||
                   !(s_r.burst || s_r.bursting)) begin
                  s_nxt.st = RECOVER;                         // [RULE6]
                  s_nxt.bursting = 1'b0;
                  s_nxt.cs_n = 8'hff;
               end else if (s_r.bursting &&
                            bus.burst_inhibit_n) begin
                  // slave advances the word bits itself
                  s_nxt.wdata = s_r.wbuf[95 - 32 * s_r.beat -: 32];
               end else begin
                  // inhibited: finish remaining words one by one
                  s_nxt.bursting = 1'b0;                      // [RULE18]
                  s_nxt.st = RECOVER;
               end
            end else if (tick && s_r.tmo >= 16'(TIMEOUT - 1)) begin
               s_nxt.tea_n = 1'b0;                            // [RULE10]
               s_nxt.tmo_hit = 1'b1;
            end
         end
         RECOVER: begin
            // wait out the acknowledge before any new start
            if (tick && bus.transfer_ack_n) begin             // [RULE6]
               if (s_r.burst && !s_r.bursting && !s_r.err &&
                   s_r.beat != 2'h0) begin
                  s_nxt.st = ADDR;
                  s_nxt.start_n = 1'b0;
                  s_nxt.addr = beat_addr;                     // [RULE18]
                  s_nxt.at = AT_NORMAL;
                  s_nxt.wdata = s_r.wbuf[127 - 32 * s_r.beat -: 32];
                  s_nxt.cs_n = ~(8'h01 << s_r.addr[31:29]);
               end else begin
                  s_nxt.st = IDLE;
                  s_nxt.done = 1'b1;
               end
            end
         end
         default: s_nxt.st = IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; synchronous reset
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         s_r <= '{st: IDLE, start_n: 1'b1, tea_n: 1'b1,
                  cs_n: 8'hff, default: '0};
      end else begin
         s_r <= s_nxt;                                        // [RULE14]
      end
   end
endmodule

// ### rtl/bus_slave.sv
// memory-mapped slave: fixed wait, lane steering, parity, burst refusal
module bus_slave
   import sys_bus_pkg::*;
#(
   parameter int WAIT_CYC = SLAVE_WAIT,
   parameter int CS_SEL   = 0
) (
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic [31:0] rd_word_in,
   output      logic        wr_valid_out,
   output      logic [31:0] wr_addr_out,
   output      logic [31:0] wr_word_out,
   output      logic [3:0]  wr_lanes_out,
   output      logic        parity_err_out,
   sys_bus_if.slave         bus
);
   import sys_bus_pkg::*;

   typedef enum logic [1:0] {IDLE, BUSY, ACK} st_e;

   typedef struct packed {
      st_e         st;
      logic [7:0]  cnt;
      logic [1:0]  word;
      logic [31:0] addr;
      logic [3:0]  lanes;
      logic        rd;
      logic        ack_n;
      logic        err_n;
      logic        bi_n;
      logic [31:0] rdata;
      logic        wv;
      logic [31:0] wa;
      logic [31:0] wd;
      logic [3:0]  wl;
      logic        perr;
   } state_s;

   state_s s_r, s_nxt;
   logic   sel;
   logic [3:0] bad_par;
   logic [3:0] lanes;

   ////////////////////////////////////////////////////////////////////////
   // lane usage by size; mask bit i is lane i, lane 0 = bits 31:24
   // narrow cycles always ride the top lanes, so no address bit picks one
   always_comb begin
      case (bus.transfer_size)
         SIZE_8:  lanes = 4'h1;                                 // [RULE11]
         SIZE_16: lanes = 4'h3;                                 // [RULE11]
         default: lanes = 4'hf;                                 // [RULE11]
      endcase
   end

   assign sel = !bus.transfer_start_n && !bus.chip_select_n[CS_SEL];
   assign bad_par = (lane_parity(bus.wdata) ^ bus.wpar) & s_r.lanes;
   assign bus.transfer_ack_n       = s_r.ack_n;
   assign bus.slave_error_ack_n    = s_r.err_n;
   assign bus.burst_inhibit_n      = s_r.bi_n;
   assign bus.rdata                = s_r.rdata;
   assign bus.rpar                 = lane_parity(s_r.rdata);    // [RULE12]
   assign wr_valid_out             = s_r.wv;
   assign wr_addr_out              = s_r.wa;
   assign wr_word_out              = s_r.wd;
   assign wr_lanes_out             = s_r.wl;
   assign parity_err_out           = s_r.perr;

   ////////////////////////////////////////////////////////////////////////
   // answer each selected cycle after a fixed wait, never before two clocks
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack_n = 1'b1;
      s_nxt.err_n = 1'b1;
      s_nxt.bi_n = 1'b1;
      s_nxt.wv = 1'b0;
      case (s_r.st)
         IDLE: begin
            if (sel) begin
               s_nxt.st = BUSY;
               s_nxt.cnt = '0;
               s_nxt.word = bus.addr[3:2];
               s_nxt.addr = bus.addr;
               s_nxt.lanes = lanes;
               s_nxt.rd = bus.read_not_write;
            end
         end
         BUSY: begin
            if (!bus.transfer_error_ack_n) begin
               s_nxt.st = IDLE;                                 // [RULE8]
            end else if (s_r.cnt >= 8'(WAIT_CYC - 1)) begin
               s_nxt.st = ACK;                                  // [RULE7]
               // bad parity ends the write with error, never with ack
               if (!s_r.rd && bad_par != 4'h0) begin
                  s_nxt.err_n = 1'b0;                           // [RULE9]
                  s_nxt.perr = 1'b1;
               end else begin
                  s_nxt.ack_n = 1'b0;                           // [RULE5]
                  // refuse every flagged burst, cache line fill or DMA alike
                  s_nxt.bi_n = bus.burst_in_progress_n;         // [RULE19]
                  s_nxt.rdata = rd_word_in;
                  if (!s_r.rd) begin
                     s_nxt.wv = 1'b1;
                     s_nxt.wa = {s_r.addr[31:4], s_r.word, s_r.addr[1:0]};
                     s_nxt.wd = bus.wdata;
                     s_nxt.wl = s_r.lanes;                      // [RULE11]
                  end
               end
            end else begin
               s_nxt.cnt = s_r.cnt + 8'h1;
            end
         end
         ACK: begin
            // only one of ack or error per cycle, then release
            s_nxt.st = IDLE;                                    // [RULE23]
            s_nxt.word = s_r.word + 2'h1;                       // [RULE17]
         end
         default: s_nxt.st = IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; synchronous reset
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         s_r <= '{st: IDLE, ack_n: 1'b1, err_n: 1'b1, bi_n: 1'b1,
                  default: '0};
      end else begin
         s_r <= s_nxt;                                          // [RULE14]
      end
   end
endmodule

// ### test/sys_bus_props.sv
// concurrent checks on the wires between bus master and bus slave
module sys_bus_props
   import sys_bus_pkg::*;
#(
   parameter int TIMEOUT = 8
) (
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic [31:0] addr,
   input wire logic [1:0]  transfer_size,
   input wire logic        read_not_write,
   input wire logic        transfer_start_n,
   input wire logic        burst_in_progress_n,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wpar,
   input wire logic [31:0] rdata,
   input wire logic [3:0]  rpar,
   input wire logic        transfer_ack_n,
   input wire logic        transfer_error_ack_n,
   input wire logic        burst_inhibit_n,
   input wire logic        slave_error_ack_n,
   input wire logic [7:0]  chip_select_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // slack above the time-out for the master's own pipeline stages
   localparam int TO_HI = TIMEOUT + 4;

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   ////////////////////////////////////////////////////////////////////////
   // named steps of one transfer
   sequence start_sel;
      !transfer_start_n && !chip_select_n[0];
   endsequence
   sequence slave_ends;
      !transfer_ack_n || !slave_error_ack_n;
   endsequence
   sequence start_unsel;
      !transfer_start_n && chip_select_n[0];
   endsequence

   ////////////////////////////////////////////////////////////////////////
   start_pulse_a: assert property (
      !transfer_start_n |=> transfer_start_n)
      else $error("start strobe held longer than one cycle");
   ack_latency_a: assert property (
      start_sel |-> ##3 slave_ends)
      else $error("slave end of cycle not three cycles after start");
   min_length_a: assert property (
      !transfer_start_n |-> transfer_ack_n && slave_error_ack_n)
      else $error("transfer ended in its start cycle");
   ack_quiet_a: assert property (
      !transfer_ack_n |-> transfer_start_n)
      else $error("new start while acknowledge low");
   burst_form_a: assert property (
      !transfer_start_n && !burst_in_progress_n
         |-> transfer_size == SIZE_32 && addr[1:0] == 2'h0)
      else $error("burst not 32-bit aligned");
   burst_refuse_a: assert property (
      !transfer_ack_n && !burst_in_progress_n |-> !burst_inhibit_n)
      else $error("slave accepted a burst beat");
   inhibit_ack_a: assert property (
      !burst_inhibit_n |-> !transfer_ack_n)
      else $error("burst inhibit without acknowledge");
   ack_err_apart_a: assert property (
      !(!transfer_ack_n && !slave_error_ack_n))
      else $error("acknowledge and error in one cycle");
   bus_timeout_a: assert property (
      start_unsel |-> ##[2:TO_HI] !transfer_error_ack_n)
      else $error("unanswered cycle not timed out");
   write_par_a: assert property (
      !transfer_ack_n && !read_not_write |-> wpar == {^wdata[7:0],
         ^wdata[15:8], ^wdata[23:16], ^wdata[31:24]})
      else $error("write lane parity wrong");
   read_par_a: assert property (
      !transfer_ack_n && read_not_write |-> rpar == {^rdata[7:0],
         ^rdata[15:8], ^rdata[23:16], ^rdata[31:24]})
      else $error("read lane parity wrong");
endmodule

// ### test/sync_cpu_bus_slave_protocol_tb.sv
// self-checking bench: master and slave joined through the bus interface
module sync_cpu_bus_slave_protocol_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sys_bus_pkg::*;
   localparam int TO = 8;       // short time-out keeps the run small

   logic         clock_in, rst_in, req_valid, req_read, req_burst, rsp_valid;
   logic         req_ready, rsp_error, rsp_timeout, rsp_perr, wr_valid;
   logic         slv_perr;
   logic [1:0]   req_size;
   logic [3:0]   req_type, wr_lanes;
   logic [7:0]   cs_use, cs_pat;
   logic [31:0]  req_addr, rd_word, wr_addr, wr_word;
   logic [127:0] req_wdata, rsp_rdata;
   logic [3:0]   lanes_seen;
   logic [31:0]  addr_seen, word_seen;
   int           errors, n_compared, n_wr;

   sys_bus_if bus_i ();
   bus_master #(.TIMEOUT(TO)) bus_master_i (
      .clock_in(clock_in), .rst_in(rst_in), .half_rate_in(1'b0),
      .cs_use_pattern_in(cs_use), .req_valid_in(req_valid),
      .req_ready_out(req_ready), .req_addr_in(req_addr),
      .req_size_in(req_size), .req_read_in(req_read),
      .req_burst_in(req_burst), .req_type_in(req_type),
      .req_wdata_in(req_wdata), .rsp_valid_out(rsp_valid),
      .rsp_rdata_out(rsp_rdata), .rsp_error_out(rsp_error),
      .rsp_timeout_out(rsp_timeout), .rsp_parity_err_out(rsp_perr),
      .cs_pattern_out(cs_pat), .bus(bus_i.master));
   bus_slave bus_slave_i (
      .clock_in(clock_in), .rst_in(rst_in), .rd_word_in(rd_word),
      .wr_valid_out(wr_valid), .wr_addr_out(wr_addr),
      .wr_word_out(wr_word), .wr_lanes_out(wr_lanes),
      .parity_err_out(slv_perr), .bus(bus_i.slave));
   sys_bus_props #(.TIMEOUT(TO)) sys_bus_props_i (
      .clock_in(clock_in), .rst_in(rst_in), .addr(bus_i.addr),
      .transfer_size(bus_i.transfer_size),
      .read_not_write(bus_i.read_not_write),
      .transfer_start_n(bus_i.transfer_start_n),
      .burst_in_progress_n(bus_i.burst_in_progress_n),
      .wdata(bus_i.wdata), .wpar(bus_i.wpar), .rdata(bus_i.rdata),
      .rpar(bus_i.rpar), .transfer_ack_n(bus_i.transfer_ack_n),
      .transfer_error_ack_n(bus_i.transfer_error_ack_n),
      .burst_inhibit_n(bus_i.burst_inhibit_n),
      .slave_error_ack_n(bus_i.slave_error_ack_n),
      .chip_select_n(bus_i.chip_select_n));

   ////////////////////////////////////////////////////////////////////////
   // clock, and a record of every write the slave hands out
   initial clock_in = 1'b0;
   always #4 clock_in = ~clock_in;
   // sampled mid-cycle so the one-cycle pulse is seen exactly once
   always @(negedge clock_in) begin
      if (wr_valid === 1'b1) begin
         n_wr++;
         lanes_seen <= wr_lanes;
         addr_seen  <= wr_addr;
         word_seen  <= wr_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one request on the user port, then wait for its response pulse
   task automatic req(input logic [31:0] a, input logic [1:0] sz,
                      input logic rd, input logic bu, input logic [3:0] ty,
                      input logic [127:0] wd);
      logic ok;
      int   i;
      req_addr  <= a;
      req_size  <= sz;
      req_read  <= rd;
      req_burst <= bu;
      req_type  <= ty;
      req_wdata <= wd;
      req_valid <= 1'b1;
      do begin
         @(negedge clock_in);
         ok = (req_ready === 1'b1);
         @(posedge clock_in);
      end while (!ok);
      req_valid <= 1'b0;
      for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) @(negedge clock_in);
      chk(i < 100, 1'b1);
      // hand back on a rising edge so the next drive is edge-aligned
      @(posedge clock_in);
   endtask

   task automatic conclude;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clock_in);
      errors++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [1:0] sizes [3];
      logic [3:0] lanes [3];
      int         w;
      sizes = '{SIZE_32, SIZE_16, SIZE_8};
      lanes = '{4'hf, 4'h3, 4'h1};
      errors = 0; n_compared = 0; n_wr = 0;
      rst_in = 1'b1; req_valid = 1'b0; req_addr = 32'h0; req_size = 2'h0;
      req_read = 1'b0; req_burst = 1'b0; req_type = AT_NORMAL;
      req_wdata = 128'h0; cs_use = 8'h5a; rd_word = 32'h1234_5678;
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      chk(cs_pat, 8'h5a);
      for (int k = 0; k < 3; k++) begin
         w = n_wr;
         req(32'h0000_0100 + k, sizes[k], 1'b0, 1'b0, AT_NORMAL,
             {32'hc3a5_9617, 96'h0});
         chk(rsp_error, 1'b0);
         chk(n_wr - w, 1);
         chk(lanes_seen, lanes[k]);
         chk(addr_seen, 32'h0000_0100 + k);
      end
      chk(word_seen[31:24], 8'hc3);
      req(32'h0000_0200, SIZE_32, 1'b0, 1'b0, AT_NORMAL,
          {32'hdead_beef, 96'h0});
      chk(word_seen, 32'hdead_beef);
      chk(slv_perr, 1'b0);
      req(32'h0000_0040, SIZE_32, 1'b1, 1'b0, AT_NORMAL, 128'h0);
      chk(rsp_rdata[127:96], 32'h1234_5678);
      chk({rsp_error, rsp_perr}, 2'h0);
      req(32'h0000_0080, SIZE_32, 1'b1, 1'b1, AT_BURST, 128'h0);
      chk(rsp_rdata, {4{32'h1234_5678}});
      chk(rsp_error, 1'b0);
      req(32'h0000_00c0, SIZE_32, 1'b1, 1'b1, AT_DMA, 128'h0);
      chk(rsp_rdata, {4{32'h1234_5678}});
      req(32'h0000_00d0, SIZE_32, 1'b1, 1'b1, AT_NORMAL, 128'h0);
      chk(rsp_rdata, {32'h1234_5678, 96'h0});
      req(32'h2000_0000, SIZE_32, 1'b1, 1'b0, AT_NORMAL, 128'h0);
      chk({rsp_error, rsp_timeout}, 2'h3);
      rd_word <= 32'h0f1e_2d3c;
      req(32'h0000_0044, SIZE_32, 1'b1, 1'b0, AT_NORMAL, 128'h0);
      chk(rsp_rdata[127:96], 32'h0f1e_2d3c);
      chk({rsp_error, rsp_timeout}, 2'h0);
      conclude();
   end
endmodule
